// *** pcdbc_pkg.sv ***
// pcdbc_pkg: offsets, field positions and reset values of the phy command/data block control register
// assumes: a 32-bit ahb-lite register space, one aligned word per register
package pcdbc_pkg;

  localparam logic [7:0] PCDBC_OFS_CTRL  = 8'h20;
  localparam logic [7:0] PCDBC_OFS_GATE  = 8'h40;
  localparam int         PCDBC_B_LOCK1   = 25;
  localparam int         PCDBC_B_LOCK0   = 24;
  localparam int         PCDBC_B_LOCKC   = 16;
  localparam int         PCDBC_B_AUTOIO  = 15;
  localparam int         PCDBC_B_BIAS    = 14;
  localparam int         PCDBC_B_UPD     = 13;
  localparam int         PCDBC_B_PHASE   = 12;
  localparam int         PCDBC_B_SIO     = 3;
  localparam int         PCDBC_B_GATEEN  = 0;
  localparam logic [31:0] PCDBC_RW_MASK  = 32'h0000_7008;
  localparam logic [31:0] PCDBC_CTRL_RST = 32'h0000_0000;
  localparam logic        PCDBC_GATE_RST = 1'b0;

  typedef enum logic [1:0]
  {
    PCDBC_ST_IDLE = 2'b00,
    PCDBC_ST_RD   = 2'b01,
    PCDBC_ST_WR   = 2'b10
  } pcdbc_phase_t;

endpackage

// *** pcdbc_sync.sv ***
// pcdbc_sync: two-flop synchroniser for a bundle of level inputs
// assumes: inputs are slow levels from another domain
module pcdbc_sync
  import pcdbc_pkg::*;
#(
  parameter int W = 3
)
(
  input  wire logic         i_ref_clk,
  input  wire logic         i_rstn,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  genvar g;
  generate
    for (g = 0; g < W; g++)
    begin : g_bit
      logic meta_q;
      logic sync_q;
      always_ff @(posedge i_ref_clk or negedge i_rstn)
      begin
        if (!i_rstn)
        begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
        end
        else
        begin
          meta_q <= i_async[g];
          sync_q <= meta_q;
        end
      end
      assign o_sync[g] = sync_q;
    end
  endgenerate

endmodule

// *** pcdbc_ctrl.sv ***
// pcdbc_ctrl: phy command/data block control register with automatic i/o gating
// assumes: ahb-lite single word transfers; dll lock flags come from the phy as async levels
//
// Notes on behaviour
// (R01) in ddr2, software keeps bit 3 equal to the strobe-disable bit of the emr image
// (R02) bit 25 is read-only lane 1 dll lock flag
// (R03) bit 24 is read-only lane 0 dll lock flag
// (R04) bit 16 is read-only command-block dll lock flag, ddr3 only
// (R05) bit 15 reads whether automatic i/o gating is enabled
// (R06) gating plus power-down forces command/address driver and data receiver off
// (R07) gating plus self-refresh forces clock, cmd/addr, odt drivers and receiver off
// (R08) bit 14 selects internal (1) or external (0) data-receiver bias
// (R09) bit 13 selects continuous or strobe-gated slave dll code update
// (R10) bit 12 sets memory clock phase: 0 half cycle, 1 three quarters
// (R11) bit 3 selects differential (0) or single-ended (1) data strobe
// (R12) reserved bits 31:26 and 23:17 read zero and ignore writes
//
// Chosen here: the AHB-Lite register port.
module pcdbc_ctrl
  import pcdbc_pkg::*;
(
  input  wire logic        i_ref_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic      [31:0] o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  input  wire logic        i_dll_lock_lane0,
  input  wire logic        i_dll_lock_lane1,
  input  wire logic        i_dll_lock_cmd,
  input  wire logic        i_auto_pdn,
  input  wire logic        i_self_refresh,
  input  wire logic        i_clkoen,
  input  wire logic        i_cmdaddroen,
  input  wire logic        i_odtoen,
  input  wire logic        i_dqie,
  output logic             o_clkoen,
  output logic             o_cmdaddroen,
  output logic             o_odtoen,
  output logic             o_dqie,
  output logic             o_self_bias,
  output logic             o_dll_upd_cont,
  output logic             o_clk_phase_3q,
  output logic             o_dqs_single
);

  // ****************************************************************
  // synchronised lock flags
  // ****************************************************************
  logic [2:0] lock_s;

  pcdbc_sync #(.W(3)) u_sync
  (
    .i_ref_clk (i_ref_clk),
    .i_rstn    (i_rstn),
    .i_async   ({i_dll_lock_cmd, i_dll_lock_lane1, i_dll_lock_lane0}),
    .o_sync    (lock_s)
  );

  // ****************************************************************
  // ahb-lite slave
  // ****************************************************************
  pcdbc_phase_t ph_q;
  logic [7:0]   adr_q;
  logic [31:0]  ctrl_q;
  logic         gate_q;
  logic [31:0]  rdata_q;

  wire          take     = i_hsel & i_htrans[1] & i_hready;
  wire          wr_ctrl  = (ph_q == PCDBC_ST_WR) && (adr_q == PCDBC_OFS_CTRL);
  wire          wr_gate  = (ph_q == PCDBC_ST_WR) && (adr_q == PCDBC_OFS_GATE);
  wire [31:0]   ctrl_d   = (i_hwdata & PCDBC_RW_MASK) | (ctrl_q & ~PCDBC_RW_MASK); // R12
  // forward a write in its data phase so a back-to-back read sees it
  wire [31:0]   ctrl_now = wr_ctrl ? ctrl_d : ctrl_q;
  wire          gate_now = wr_gate ? i_hwdata[PCDBC_B_GATEEN] : gate_q;
  wire [31:0]   status_w = ctrl_now
                         | (32'(lock_s[1]) << PCDBC_B_LOCK1)   // R02
                         | (32'(lock_s[0]) << PCDBC_B_LOCK0)   // R03
                         | (32'(lock_s[2]) << PCDBC_B_LOCKC)   // R04
                         | (32'(gate_now) << PCDBC_B_AUTOIO);  // R05
  wire [7:0]    adr_now  = i_haddr[7:0];
  wire [31:0]   rsel     = (adr_now == PCDBC_OFS_CTRL) ? status_w :
                           (adr_now == PCDBC_OFS_GATE) ? 32'(gate_now) : 32'h0000_0000;

  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      ph_q    <= PCDBC_ST_IDLE;
      adr_q   <= 8'h00;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      ph_q    <= !take ? PCDBC_ST_IDLE : (i_hwrite ? PCDBC_ST_WR : PCDBC_ST_RD);
      adr_q   <= take ? adr_now : adr_q;
      rdata_q <= (take && !i_hwrite) ? rsel : rdata_q;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      ctrl_q <= PCDBC_CTRL_RST;
      gate_q <= PCDBC_GATE_RST;
    end
    else
    begin
      ctrl_q <= wr_ctrl ? ctrl_d : ctrl_q;
      gate_q <= wr_gate ? i_hwdata[PCDBC_B_GATEEN] : gate_q;
    end
  end

  assign o_hrdata    = rdata_q;
  assign o_hreadyout = 1'b1;
  assign o_hresp     = 1'b0;

  // ****************************************************************
  // phy controls and automatic i/o gating
  // ****************************************************************
  wire gate_pd = gate_q & i_auto_pdn;     // R06
  wire gate_sr = gate_q & i_self_refresh; // R07

  assign o_cmdaddroen   = i_cmdaddroen & ~gate_pd & ~gate_sr; // R06 R07
  assign o_dqie         = i_dqie & ~gate_pd & ~gate_sr;       // R06 R07
  assign o_clkoen       = i_clkoen & ~gate_sr;                // R07
  assign o_odtoen       = i_odtoen & ~gate_sr;                // R07
  assign o_self_bias    = ctrl_q[PCDBC_B_BIAS];               // R08
  assign o_dll_upd_cont = ctrl_q[PCDBC_B_UPD];                // R09
  assign o_clk_phase_3q = ctrl_q[PCDBC_B_PHASE];              // R10
  assign o_dqs_single   = ctrl_q[PCDBC_B_SIO];                // R11

  // ****************************************************************
  // assertions
  // ****************************************************************
  property p_gate_pd;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      (gate_q && i_auto_pdn) |-> (!o_cmdaddroen && !o_dqie);
  endproperty
  a_gate_pd: assert property (p_gate_pd) else $error("power-down gating failed"); // R06

  property p_gate_sr;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      (gate_q && i_self_refresh) |-> (!o_clkoen && !o_odtoen && !o_cmdaddroen && !o_dqie);
  endproperty
  a_gate_sr: assert property (p_gate_sr) else $error("self-refresh gating failed"); // R07

  property p_lock1;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      (take && !i_hwrite && adr_now == PCDBC_OFS_CTRL) |=> (o_hrdata[25] == $past(lock_s[1]));
  endproperty
  a_lock1: assert property (p_lock1) else $error("lane 1 lock bit wrong"); // R02

  property p_lock0;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      (take && !i_hwrite && adr_now == PCDBC_OFS_CTRL) |=> (o_hrdata[24] == $past(lock_s[0]));
  endproperty
  a_lock0: assert property (p_lock0) else $error("lane 0 lock bit wrong"); // R03

  property p_lockc;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      (take && !i_hwrite && adr_now == PCDBC_OFS_CTRL) |=> (o_hrdata[16] == $past(lock_s[2]));
  endproperty
  a_lockc: assert property (p_lockc) else $error("cmd lock bit wrong"); // R04

  property p_autoio;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      (take && !i_hwrite && adr_now == PCDBC_OFS_CTRL) |=> (o_hrdata[15] == $past(gate_now));
  endproperty
  a_autoio: assert property (p_autoio) else $error("auto gating bit wrong"); // R05

  property p_bias;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      wr_ctrl |=> (o_self_bias == $past(i_hwdata[14]) && o_dll_upd_cont == $past(i_hwdata[13]));
  endproperty
  a_bias: assert property (p_bias) else $error("bias or update bit not stored"); // R08 R09

  property p_phase;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      wr_ctrl |=> (o_clk_phase_3q == $past(i_hwdata[12]) && o_dqs_single == $past(i_hwdata[3]));
  endproperty
  a_phase: assert property (p_phase) else $error("phase or strobe bit not stored"); // R10 R11

  property p_resv;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      (ph_q == PCDBC_ST_RD && adr_q == PCDBC_OFS_CTRL) |-> (o_hrdata[31:26] == 6'h00 && o_hrdata[23:17] == 7'h00);
  endproperty
  a_resv: assert property (p_resv) else $error("reserved bits not zero"); // R12

  property p_resv_store;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      wr_ctrl |=> ((ctrl_q & ~PCDBC_RW_MASK) == 32'h0000_0000);
  endproperty
  a_resv_store: assert property (p_resv_store) else $error("reserved bits stored"); // R12

  property p_gate_reg;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      wr_gate |=> (gate_q == $past(i_hwdata[PCDBC_B_GATEEN]));
  endproperty
  a_gate_reg: assert property (p_gate_reg) else $error("gating enable not stored"); // R05

  property p_gate_off;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      !gate_q |-> (o_clkoen == i_clkoen && o_cmdaddroen == i_cmdaddroen &&
                   o_odtoen == i_odtoen && o_dqie == i_dqie);
  endproperty
  a_gate_off: assert property (p_gate_off) else $error("enables gated while gating disabled"); // R06 R07

  property p_pd_keep;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      (gate_q && i_auto_pdn && !i_self_refresh) |-> (o_clkoen == i_clkoen && o_odtoen == i_odtoen);
  endproperty
  a_pd_keep: assert property (p_pd_keep) else $error("power-down gated clock or odt"); // R06

  c_write: cover property (@(posedge i_ref_clk) disable iff (!i_rstn) wr_ctrl);
  c_pd: cover property (@(posedge i_ref_clk) disable iff (!i_rstn) gate_pd);
  c_sr: cover property (@(posedge i_ref_clk) disable iff (!i_rstn) gate_sr);
  c_both: cover property (@(posedge i_ref_clk) disable iff (!i_rstn) gate_pd && gate_sr);
  c_rd_lock: cover property (@(posedge i_ref_clk) disable iff (!i_rstn) take && !i_hwrite && lock_s[2]);

endmodule

// *** pcdbc_phy_model.sv ***
// pcdbc_phy_model: phy side of the block, dll lock levels that settle a few cycles after a request
// assumes: the bench drives the lock request in the i_ref_clk domain
module pcdbc_phy_model
#(
  parameter int   LAT        = 3,
  parameter logic STROBE_OFF = 1'b1
)
(
  input  wire logic       i_ref_clk,
  input  wire logic [2:0] i_lock_req,
  output logic      [2:0] o_lock,
  output logic            o_strobe_off
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [3*LAT-1:0] lock_q = '0;

  // lock takes a few cycles to appear, like a real dll
  always @(posedge i_ref_clk)
  begin
    lock_q <= {lock_q[3*LAT-4:0], i_lock_req};
  end

  assign o_lock = lock_q[3*LAT-1 -: 3];

  // strobe-disable setting in the memory's extended mode image; software mirrors it
  assign o_strobe_off = STROBE_OFF;
endmodule

// *** pcdbc_ctrl_tb.sv ***
// pcdbc_ctrl_tb: register, lock flag and i/o gating checks over ahb-lite
// assumes: pcdbc_phy_model drives the lock levels; zero wait-state slave
module pcdbc_ctrl_tb
  import pcdbc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0, pdn = 1'b0, sr = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = '0, hwdata = '0, rd;
  logic [2:0]  lreq = 3'h0;
  logic [3:0]  sw = 4'hf;
  wire  [31:0] hrdata;
  wire  [3:0]  gated, cfg;
  wire  [2:0]  lock;
  wire         hrdy, hresp, strobe_off;
  int          n_errors = 0, n_compared = 0;
  int          bits [4] = '{14, 13, 12, 3};
  int          lbit [3] = '{24, 25, 16};

  initial
  begin
    forever #25 clk = ~clk;
  end

  pcdbc_phy_model u_phy (.i_ref_clk(clk), .i_lock_req(lreq), .o_lock(lock), .o_strobe_off(strobe_off));

  pcdbc_ctrl dut (.i_ref_clk(clk), .i_rstn(rstn), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hrdy), .o_hrdata(hrdata),
    .o_hreadyout(hrdy), .o_hresp(hresp), .i_dll_lock_lane0(lock[0]), .i_dll_lock_lane1(lock[1]),
    .i_dll_lock_cmd(lock[2]), .i_auto_pdn(pdn), .i_self_refresh(sr), .i_clkoen(sw[3]),
    .i_cmdaddroen(sw[2]), .i_odtoen(sw[1]), .i_dqie(sw[0]), .o_clkoen(gated[3]),
    .o_cmdaddroen(gated[2]), .o_odtoen(gated[1]), .o_dqie(gated[0]), .o_self_bias(cfg[3]),
    .o_dll_upd_cont(cfg[2]), .o_clk_phase_3q(cfg[1]), .o_dqs_single(cfg[0]));

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wait_rdy();
    int k;
    k = 0;
    @(posedge clk);
    while (hrdy !== 1'b1 && k < 50)
    begin
      @(posedge clk);
      k++;
    end
    if (hrdy !== 1'b1)
    begin
      n_errors++;
      test_done();
    end
  endtask

  // one single word transfer: address phase, then data phase
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string w);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e, w);
  endtask

  initial
  begin
    logic [3:0] e;
    logic [1:0] ps;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd_chk(PCDBC_OFS_CTRL, 32'h0, "ctrl reset");
    bus(1'b1, PCDBC_OFS_CTRL, 32'hffff_ffff, rd);
    rd_chk(PCDBC_OFS_CTRL, 32'h0000_7008, "ctrl writable");
    foreach (bits[i])
    begin
      bus(1'b1, PCDBC_OFS_CTRL, 32'h1 << bits[i], rd);
      rd_chk(PCDBC_OFS_CTRL, 32'h1 << bits[i], "ctrl bit");
      chk({28'h0, cfg}, 32'h8 >> i, "config outputs");
    end
    for (int i = 0; i < 3; i++)
    begin
      lreq <= 3'h1 << i;
      // model latency plus two sync flops
      repeat (8) @(posedge clk);
      rd_chk(PCDBC_OFS_CTRL, 32'h8 | (32'h1 << lbit[i]), "lock flag");
    end
    for (int g = 0; g < 2; g++)
    begin
      bus(1'b1, PCDBC_OFS_GATE, 32'(g), rd);
      rd_chk(PCDBC_OFS_CTRL, 32'h0001_0008 | (32'(g) << 15), "gate flag");
      for (int s = 0; s < 4; s++)
      begin
        ps = 2'(s);
        @(posedge clk);
        {pdn, sr} <= ps;
        @(negedge clk);
        e = (g == 0) ? 4'hf : {~ps[0], ~|ps, ~ps[0], ~|ps};
        chk({28'h0, gated}, {28'h0, e}, "gated enables");
      end
      @(posedge clk);
      {pdn, sr} <= 2'h0;
    end
    sw <= 4'h5;
    @(negedge clk);
    chk({28'h0, gated}, 32'h5, "enable pass-through");
    @(posedge clk);
    bus(1'b1, PCDBC_OFS_CTRL, 32'(strobe_off) << PCDBC_B_SIO, rd);
    rd_chk(PCDBC_OFS_CTRL, 32'h0001_8000 | (32'(strobe_off) << PCDBC_B_SIO), "strobe readback");
    chk({31'h0, cfg[0]}, {31'h0, strobe_off}, "strobe style");
    bus(1'b1, 8'h44, 32'hffff_ffff, rd);
    rd_chk(8'h44, 32'h0, "unmapped");
    chk({31'h0, hresp}, 32'h0, "response");
    test_done();
  end
endmodule
